// ### osc_regs_pkg.sv
// Constants for the oscillator control and status register block
package osc_regs_pkg;
  // Register addresses
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  // Control field positions
  localparam int CTRL_PLL_BIT = 7;
  localparam int IFS_HI       = 6;
  localparam int IFS_LO       = 3;
  localparam int SCS_HI       = 1;
  localparam int SCS_LO       = 0;
  // Status bit positions
  localparam int ST_XTAL = 7;
  localparam int ST_MULTIPLIER_READY = 6;
  localparam int ST_CFG  = 5;
  localparam int ST_HFR  = 4;
  localparam int ST_HFL  = 3;
  localparam int ST_MFR  = 2;
  localparam int ST_LFR  = 1;
  localparam int ST_HFS  = 0;
  // Reset values
  localparam logic [3:0] IFS_RESET = 4'h7;
  localparam logic [1:0] SCS_RESET = 2'h0;
  // Start-up timer length in oscillations
  localparam logic [10:0] OST_COUNT = 11'h400;
  // Clock sources
  typedef enum logic [1:0] {
    SRC_CONFIG = 2'b00,
    SRC_XTAL   = 2'b01,
    SRC_INT    = 2'b10
  } src_t;
  // Internal oscillator used by a tap
  typedef enum logic [1:0] {
    OSC_LF = 2'b00,
    OSC_MF = 2'b01,
    OSC_HF = 2'b10
  } osc_t;
endpackage

// ### osc_tap_if.sv
// Interface carrying a frequency select decode between modules
`timescale 1ns/100ps
interface osc_tap_if;
  logic [3:0]               code;   // Frequency select code
  logic                     pll_on; // Multiplier active
  osc_regs_pkg::osc_t       osc;    // Chosen oscillator
  logic [3:0]               div_log;// Power-of-two divide from top tap
  logic                     mult;   // Tap multiplied by four
  modport dec (input code, pll_on, output osc, div_log, mult);
  modport use_side (output code, pll_on, input osc, div_log, mult);
endinterface

// ### osc_tap_decode.sv
// Decoder of the internal frequency select field
`timescale 1ns/100ps
module osc_tap_decode (
  osc_tap_if.dec t
);
  // Maps code to oscillator and divide; HF 16 MHz top is divide 0
  always_comb begin
    t.mult    = 1'b0;
    t.osc     = osc_regs_pkg::OSC_HF;
    t.div_log = 4'h0;
    case (t.code)
      4'h0, 4'h1: begin
        t.osc     = osc_regs_pkg::OSC_LF;
        t.div_log = 4'h0;
      end
      4'h2: begin
        t.osc     = osc_regs_pkg::OSC_MF;
        t.div_log = 4'h4;
      end
      4'h3: begin
        t.osc     = osc_regs_pkg::OSC_HF;
        t.div_log = 4'h9;
      end
      4'h4, 4'h5, 4'h6, 4'h7: begin
        t.osc     = osc_regs_pkg::OSC_MF;
        t.div_log = 4'h7 - t.code;
      end
      4'hE: begin
        t.div_log = 4'h1;
      end
      4'hF: begin
        t.div_log = 4'h0;
        t.mult    = t.pll_on;
      end
      default: begin
        t.div_log = 4'hF - t.code;
      end
    endcase
  end
endmodule

// ### osc_ctrl_regs.sv
// Oscillator control and status registers with source switching
`timescale 1ns/100ps
module osc_ctrl_regs (
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  input  wire logic [1:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       PLL_CONFIG_FORCE,
  input  wire logic       LOWFREQ_XTAL_ENABLE,
  input  wire logic       LOWFREQ_XTAL_READY,
  input  wire logic       MULTIPLIER_READY,
  input  wire logic       HF_OSC_READY,
  input  wire logic       HF_OSC_LOCKED,
  input  wire logic       MF_OSC_READY,
  input  wire logic       LF_OSC_READY,
  input  wire logic       HF_OSC_STABLE,
  input  wire logic       EXT_OSC_TICK,
  input  wire logic       SLEEP_ENTER,
  output logic            PLL_ENABLE,
  output logic      [1:0] CLK_SOURCE,
  output logic      [1:0] INT_OSC_SEL,
  output logic      [3:0] INT_DIV_LOG,
  output logic            INT_MULT
);
  logic       pll_soft_enable_ff;        // Software multiplier enable
  logic [3:0] internal_freq_select_ff;   // Frequency tap
  logic [1:0] sysclk_source_select_ff;   // Source select
  logic [10:0] startup_timer_ff;         // Oscillation count
  logic       configured_clock_running_ff; // Switched to configured clock
  logic       wr_ctrl;                   // Control write strobe
  logic [7:0] ctrl_rd;                   // Control read value
  logic [7:0] stat_rd;                   // Status read value
  logic       pll_on;                    // Multiplier active request
  osc_tap_if  tap ();

  assign wr_ctrl = WR && (ADDR == osc_regs_pkg::ADDR_CTRL);
  assign pll_on  = PLL_CONFIG_FORCE || pll_soft_enable_ff;

  // Tap decoder instance
  assign tap.code   = internal_freq_select_ff;
  assign tap.pll_on = pll_on;
  osc_tap_decode u_dec (.t(tap));

  // Control register fields; bit 2 is never stored
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pll_soft_enable_ff      <= 1'b0;
      internal_freq_select_ff <= osc_regs_pkg::IFS_RESET;
      sysclk_source_select_ff <= osc_regs_pkg::SCS_RESET;
    end else if (wr_ctrl) begin
      pll_soft_enable_ff      <= WDATA[osc_regs_pkg::CTRL_PLL_BIT];
      internal_freq_select_ff <= WDATA[osc_regs_pkg::IFS_HI:osc_regs_pkg::IFS_LO];
      sysclk_source_select_ff <= WDATA[osc_regs_pkg::SCS_HI:osc_regs_pkg::SCS_LO];
    end
  end

  // Start-up timer: restarts on source change or sleep, counts ticks
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      startup_timer_ff <= 11'h000;
    end else if ((wr_ctrl && WDATA[osc_regs_pkg::SCS_HI:osc_regs_pkg::SCS_LO]
                 != sysclk_source_select_ff) || SLEEP_ENTER) begin
      startup_timer_ff <= 11'h000;
    end else if (EXT_OSC_TICK && startup_timer_ff != osc_regs_pkg::OST_COUNT) begin
      startup_timer_ff <= startup_timer_ff + 11'h001;
    end
  end

  // Configured clock taken over only after full count
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      configured_clock_running_ff <= 1'b0;
    end else if (sysclk_source_select_ff != osc_regs_pkg::SRC_CONFIG
                 || startup_timer_ff != osc_regs_pkg::OST_COUNT) begin
      configured_clock_running_ff <= 1'b0;
    end else begin
      configured_clock_running_ff <= 1'b1;
    end
  end

  // Clock routing outputs
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PLL_ENABLE  <= 1'b0;
      CLK_SOURCE  <= osc_regs_pkg::SRC_INT;
      INT_OSC_SEL <= osc_regs_pkg::OSC_MF;
      INT_DIV_LOG <= 4'h0;
      INT_MULT    <= 1'b0;
    end else begin
      PLL_ENABLE  <= pll_on;
      INT_OSC_SEL <= tap.osc;
      INT_DIV_LOG <= tap.div_log;
      INT_MULT    <= tap.mult;
      if (sysclk_source_select_ff[1]) begin
        CLK_SOURCE <= osc_regs_pkg::SRC_INT;
      end else if (sysclk_source_select_ff[0]) begin
        CLK_SOURCE <= osc_regs_pkg::SRC_XTAL;
      end else if (configured_clock_running_ff) begin
        CLK_SOURCE <= osc_regs_pkg::SRC_CONFIG;
      end else begin
        CLK_SOURCE <= osc_regs_pkg::SRC_INT;
      end
    end
  end

  // Read values
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[osc_regs_pkg::CTRL_PLL_BIT] = pll_soft_enable_ff;
    ctrl_rd[osc_regs_pkg::IFS_HI:osc_regs_pkg::IFS_LO] = internal_freq_select_ff;
    ctrl_rd[osc_regs_pkg::SCS_HI:osc_regs_pkg::SCS_LO] = sysclk_source_select_ff;
    stat_rd = 8'h00;
    stat_rd[osc_regs_pkg::ST_XTAL] = LOWFREQ_XTAL_ENABLE && LOWFREQ_XTAL_READY;
    stat_rd[osc_regs_pkg::ST_MULTIPLIER_READY] = MULTIPLIER_READY;
    stat_rd[osc_regs_pkg::ST_CFG]  = configured_clock_running_ff;
    stat_rd[osc_regs_pkg::ST_HFR]  = HF_OSC_READY;
    stat_rd[osc_regs_pkg::ST_HFL]  = HF_OSC_LOCKED;
    stat_rd[osc_regs_pkg::ST_MFR]  = MF_OSC_READY;
    stat_rd[osc_regs_pkg::ST_LFR]  = LF_OSC_READY;
    stat_rd[osc_regs_pkg::ST_HFS]  = HF_OSC_STABLE;
  end

  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (RD && ADDR == osc_regs_pkg::ADDR_CTRL) begin
      RDATA <= ctrl_rd;
    end else if (RD && ADDR == osc_regs_pkg::ADDR_STAT) begin
      RDATA <= stat_rd;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Assertions
  sequence s_count_done;
    startup_timer_ff == osc_regs_pkg::OST_COUNT;
  endsequence
  property p_pll_follow;
    @(posedge MCLK) disable iff (!RST_N) RST_N && PLL_CONFIG_FORCE |=> PLL_ENABLE;
  endproperty
  a_pll_follow: assert property (p_pll_follow) else $error("multiplier not forced");
  property p_bit2_zero;
    @(posedge MCLK) disable iff (!RST_N)
      RD && ADDR == osc_regs_pkg::ADDR_CTRL |=> !RDATA[2];
  endproperty
  a_bit2_zero: assert property (p_bit2_zero) else $error("bit 2 reads one");
  property p_cfg_needs_count;
    @(posedge MCLK) disable iff (!RST_N)
      $rose(configured_clock_running_ff) |-> $past(startup_timer_ff) == osc_regs_pkg::OST_COUNT;
  endproperty
  a_cfg_needs_count: assert property (p_cfg_needs_count) else $error("early switch");
  property p_restart;
    @(posedge MCLK) disable iff (!RST_N)
      wr_ctrl && WDATA[1:0] != sysclk_source_select_ff |=> startup_timer_ff == 11'h000;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");
  property p_int_src;
    @(posedge MCLK) disable iff (!RST_N)
      sysclk_source_select_ff[1] |=> CLK_SOURCE == osc_regs_pkg::SRC_INT;
  endproperty
  a_int_src: assert property (p_int_src) else $error("internal not selected");
  property p_stat_read;
    @(posedge MCLK) disable iff (!RST_N)
      RD && ADDR == osc_regs_pkg::ADDR_STAT ##0 s_count_done
      |=> RDATA[osc_regs_pkg::ST_CFG] == $past(configured_clock_running_ff);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status bit 5 wrong");
  property p_xtal;
    @(posedge MCLK) disable iff (!RST_N)
      RD && ADDR == osc_regs_pkg::ADDR_STAT && !LOWFREQ_XTAL_ENABLE |=> !RDATA[7];
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal ready while disabled");
  property p_hf;
    @(posedge MCLK) disable iff (!RST_N)
      RD && ADDR == osc_regs_pkg::ADDR_STAT |=> RDATA[4:3] == $past({HF_OSC_READY, HF_OSC_LOCKED});
  endproperty
  a_hf: assert property (p_hf) else $error("hf status wrong");
  // Decoder outputs for every select code, one cycle after the field
  property p_code_01;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code[3:1] == 3'h0 |=> INT_OSC_SEL == osc_regs_pkg::OSC_LF && INT_DIV_LOG == 4'h0;
  endproperty
  a_code_01: assert property (p_code_01) else $error("code 0/1 decode wrong");
  property p_code_2;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'h2 |=> INT_OSC_SEL == osc_regs_pkg::OSC_MF && INT_DIV_LOG == 4'h4;
  endproperty
  a_code_2: assert property (p_code_2) else $error("code 2 decode wrong");
  property p_code_3;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'h3 |=> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h9;
  endproperty
  a_code_3: assert property (p_code_3) else $error("code 3 decode wrong");
  property p_code_4;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'h4 |=> INT_OSC_SEL == osc_regs_pkg::OSC_MF && INT_DIV_LOG == 4'h3;
  endproperty
  a_code_4: assert property (p_code_4) else $error("code 4 decode wrong");
  property p_code_5;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'h5 |=> INT_OSC_SEL == osc_regs_pkg::OSC_MF && INT_DIV_LOG == 4'h2;
  endproperty
  a_code_5: assert property (p_code_5) else $error("code 5 decode wrong");
  property p_code_6;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'h6 |=> INT_OSC_SEL == osc_regs_pkg::OSC_MF && INT_DIV_LOG == 4'h1;
  endproperty
  a_code_6: assert property (p_code_6) else $error("code 6 decode wrong");
  property p_code_7;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'h7 |=> INT_OSC_SEL == osc_regs_pkg::OSC_MF && INT_DIV_LOG == 4'h0;
  endproperty
  a_code_7: assert property (p_code_7) else $error("code 7 decode wrong");
  property p_code_8;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'h8 |=> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h7;
  endproperty
  a_code_8: assert property (p_code_8) else $error("code 8 decode wrong");
  property p_code_9;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'h9 |=> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h6;
  endproperty
  a_code_9: assert property (p_code_9) else $error("code 9 decode wrong");
  property p_code_a;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'hA |=> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h5;
  endproperty
  a_code_a: assert property (p_code_a) else $error("code A decode wrong");
  property p_code_b;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'hB |=> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h4;
  endproperty
  a_code_b: assert property (p_code_b) else $error("code B decode wrong");
  property p_code_c;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'hC |=> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h3;
  endproperty
  a_code_c: assert property (p_code_c) else $error("code C decode wrong");
  property p_code_d;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'hD |=> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h2;
  endproperty
  a_code_d: assert property (p_code_d) else $error("code D decode wrong");
  property p_code_e;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'hE |=> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h1;
  endproperty
  a_code_e: assert property (p_code_e) else $error("code E decode wrong");
  property p_code_f;
    @(posedge MCLK) disable iff (!RST_N)
      tap.code == 4'hF |=> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h0;
  endproperty
  a_code_f: assert property (p_code_f) else $error("code F decode wrong");
  // Software enable alone turns the multiplier on
  property p_pll_soft;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && pll_soft_enable_ff |=> PLL_ENABLE;
  endproperty
  a_pll_soft: assert property (p_pll_soft) else $error("multiplier not enabled");
  // Neither force nor enable keeps the multiplier off
  property p_pll_off;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && !PLL_CONFIG_FORCE && !pll_soft_enable_ff |=> !PLL_ENABLE;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("multiplier on unasked");
  // Multiplication only ever applies to the top high-frequency tap
  property p_mult_top;
    @(posedge MCLK) disable iff (!RST_N)
      INT_MULT |-> INT_OSC_SEL == osc_regs_pkg::OSC_HF && INT_DIV_LOG == 4'h0;
  endproperty
  a_mult_top: assert property (p_mult_top) else $error("multiplied lower tap");
  // Source 01 routes the low-frequency crystal
  property p_xtal_src;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && sysclk_source_select_ff == osc_regs_pkg::SRC_XTAL
      |=> CLK_SOURCE == osc_regs_pkg::SRC_XTAL;
  endproperty
  a_xtal_src: assert property (p_xtal_src) else $error("crystal not selected");
  // Source 00 stays on the internal clock until the switch is granted
  property p_int_wait;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && sysclk_source_select_ff == osc_regs_pkg::SRC_CONFIG && !configured_clock_running_ff
      |=> CLK_SOURCE == osc_regs_pkg::SRC_INT;
  endproperty
  a_int_wait: assert property (p_int_wait) else $error("left internal early");
  // Source 00 chosen and the full count reached
  sequence s_cfg_ready;
    sysclk_source_select_ff == osc_regs_pkg::SRC_CONFIG ##0 s_count_done;
  endsequence
  // Ready flag set, then the configured clock taken over a cycle later
  property p_cfg_switch;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N ##0 s_cfg_ready ##1 sysclk_source_select_ff == osc_regs_pkg::SRC_CONFIG
      |=> CLK_SOURCE == osc_regs_pkg::SRC_CONFIG;
  endproperty
  a_cfg_switch: assert property (p_cfg_switch) else $error("no switch to configured");
  // Running flag follows a completed count on source 00
  property p_cfg_flag;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N ##0 s_cfg_ready |=> configured_clock_running_ff;
  endproperty
  a_cfg_flag: assert property (p_cfg_flag) else $error("running flag not set");
  // Any other source clears the running flag
  property p_cfg_clear;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && sysclk_source_select_ff != osc_regs_pkg::SRC_CONFIG
      |=> !configured_clock_running_ff;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("running flag stuck");
  // Entering sleep aborts the start-up count
  property p_sleep;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && SLEEP_ENTER |=> startup_timer_ff == 11'h000;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not abort count");
  // Each external tick advances an unfinished count by one
  property p_count;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && EXT_OSC_TICK && !SLEEP_ENTER && !wr_ctrl
        && startup_timer_ff != osc_regs_pkg::OST_COUNT
      |=> startup_timer_ff == $past(startup_timer_ff) + 11'h001;
  endproperty
  a_count: assert property (p_count) else $error("tick not counted");
  // Multiplier ready bit read back
  property p_multiplier_ready;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && RD && ADDR == osc_regs_pkg::ADDR_STAT
      |=> RDATA[osc_regs_pkg::ST_MULTIPLIER_READY] == $past(MULTIPLIER_READY);
  endproperty
  a_multiplier_ready: assert property (p_multiplier_ready) else $error("multiplier ready wrong");
  // Medium and low oscillator ready bits read back
  property p_mf_lf;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && RD && ADDR == osc_regs_pkg::ADDR_STAT
      |=> RDATA[2:1] == $past({MF_OSC_READY, LF_OSC_READY});
  endproperty
  a_mf_lf: assert property (p_mf_lf) else $error("mf or lf ready wrong");
  // High oscillator stable bit read back
  property p_hfs;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && RD && ADDR == osc_regs_pkg::ADDR_STAT
      |=> RDATA[osc_regs_pkg::ST_HFS] == $past(HF_OSC_STABLE);
  endproperty
  a_hfs: assert property (p_hfs) else $error("hf stable wrong");
  // Crystal ready shows through while its enable is set
  property p_xtal_on;
    @(posedge MCLK) disable iff (!RST_N)
      RST_N && RD && ADDR == osc_regs_pkg::ADDR_STAT && LOWFREQ_XTAL_ENABLE
      |=> RDATA[osc_regs_pkg::ST_XTAL] == $past(LOWFREQ_XTAL_READY);
  endproperty
  a_xtal_on: assert property (p_xtal_on) else $error("crystal ready hidden");
endmodule

// ### test_osc_ctrl_regs.sv
// Self-checking bench of the oscillator control and status registers
`timescale 1ns/100ps
module test_osc_ctrl_regs;
  logic        MCLK, RST_N, WR, RD, TICK, SLEEP, FORCE, XEN, PLL_ENABLE, INT_MULT;
  logic [1:0]  ADDR, CLK_SOURCE, INT_OSC_SEL;
  logic [3:0]  INT_DIV_LOG, c;
  logic [7:0]  WDATA, RDATA, st_in, ctrl;
  logic [31:0] seed;
  int          bad_count, n_checks, cfg_run;
  // Oscillator and power-of-two divide expected for each select code
  localparam int SELS [16] = '{0, 0, 1, 2, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2};
  localparam int DIVS [16] = '{0, 0, 4, 9, 3, 2, 1, 0, 7, 6, 5, 4, 3, 2, 1, 0};

  osc_ctrl_regs u_dut (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PLL_CONFIG_FORCE(FORCE), .LOWFREQ_XTAL_ENABLE(XEN),
    .LOWFREQ_XTAL_READY(st_in[7]), .MULTIPLIER_READY(st_in[6]), .HF_OSC_READY(st_in[4]),
    .HF_OSC_LOCKED(st_in[3]), .MF_OSC_READY(st_in[2]), .LF_OSC_READY(st_in[1]),
    .HF_OSC_STABLE(st_in[0]), .EXT_OSC_TICK(TICK), .SLEEP_ENTER(SLEEP),
    .PLL_ENABLE(PLL_ENABLE), .CLK_SOURCE(CLK_SOURCE), .INT_OSC_SEL(INT_OSC_SEL),
    .INT_DIV_LOG(INT_DIV_LOG), .INT_MULT(INT_MULT));

  // Free-running 200 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  // Pseudo-random source for stimulus
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Status value the bench model expects
  function automatic logic [7:0] st_exp();
    return {XEN & st_in[7], st_in[6], cfg_run[0], st_in[4:0]};
  endfunction

  // Compare one result and count it
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask

  // One-cycle read; data is looked at in the single cycle it stands
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk_pin(RDATA, exp, "read data");
  endtask

  // Pulses of the external oscillator, one per cycle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge MCLK);
      TICK <= 1'b1;
    end
    @(posedge MCLK);
    TICK <= 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #200us;
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    {RST_N, WR, RD, TICK, SLEEP, FORCE, XEN, ADDR, WDATA, st_in} = '0;
    seed    = 32'h74C2;
    cfg_run = 0;
    repeat (12) @(posedge MCLK);
    RST_N <= 1'b1;
    rd_chk(2'h0, 8'h38);
    chk_pin(8'(CLK_SOURCE), 8'h02, "source after reset");
    // Every select code with random multiplier and status inputs
    for (int i = 0; i < 16; i++) begin
      @(posedge MCLK);
      seed  = lfsr(seed);
      c     = 4'(i);
      FORCE <= seed[8];
      XEN   <= seed[9];
      st_in <= seed[23:16];
      ctrl  = {seed[7], c, seed[2], 1'b1, seed[0]} & 8'hFB;
      wr(2'h0, {seed[7], c, seed[2], 1'b1, seed[0]});
      repeat (2) @(posedge MCLK);
      #1;
      chk_pin(8'(PLL_ENABLE), 8'(FORCE | ctrl[7]), "multiplier enable");
      chk_pin(8'(INT_OSC_SEL), 8'(SELS[i]), "oscillator");
      chk_pin(8'(INT_DIV_LOG), 8'(DIVS[i]), "divide");
      chk_pin(8'(INT_MULT), 8'(c == 4'hF && (FORCE | ctrl[7])), "multiply");
      chk_pin(8'(CLK_SOURCE), 8'h02, "internal source");
      rd_chk(2'h0, ctrl);
      rd_chk(2'h1, st_exp());
    end
    // Unmapped and read-only places keep the control value
    wr(2'h2, 8'hFF);
    wr(2'h1, 8'hFF);
    rd_chk(2'h2, 8'h00);
    rd_chk(2'h0, ctrl);
    wr(2'h0, {ctrl[7:2], 2'b01});
    repeat (2) @(posedge MCLK);
    #1;
    chk_pin(8'(CLK_SOURCE), 8'h01, "crystal source");
    // Configured clock: sleep mid-count restarts the timer
    wr(2'h0, {ctrl[7:2], 2'b00});
    ticks(600);
    @(posedge MCLK);
    SLEEP <= 1'b1;
    @(posedge MCLK);
    SLEEP <= 1'b0;
    ticks(1023);
    rd_chk(2'h1, st_exp());
    chk_pin(8'(CLK_SOURCE), 8'h02, "still internal");
    ticks(1);
    @(posedge MCLK);
    #1;
    chk_pin(8'(CLK_SOURCE), 8'h02, "switch a cycle after flag");
    @(posedge MCLK);
    #1;
    cfg_run = 1;
    chk_pin(8'(CLK_SOURCE), 8'h00, "configured source");
    rd_chk(2'h1, st_exp());
    // Leaving and re-entering source 00 restarts the count
    wr(2'h0, {ctrl[7:2], 2'b10});
    cfg_run = 0;
    repeat (2) @(posedge MCLK);
    rd_chk(2'h1, st_exp());
    wr(2'h0, {ctrl[7:2], 2'b00});
    ticks(1023);
    rd_chk(2'h1, st_exp());
    chk_pin(8'(CLK_SOURCE), 8'h02, "restarted timer");
    // Second reset in mid-run
    @(posedge MCLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    rd_chk(2'h0, 8'h38);
    stop_test();
  end
endmodule
